// File: rtl/smbtf_device.sv
// Summary of operation
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Controller sends Start before any instruction
// - Watch for Start except during write
// - Stop ends transfer, back to Standby
// - Stop after read NoAck enters Standby
// - Stop closing a write starts programming
// - Capture data on rising clock edge
// - Controller changes data only while clock low
// - Transmitter releases; receiver acks ninth pulse
// - Select byte sent top bit first
// - Last select bit: 1 read, 0 write
// - Matching select byte gets acknowledge
// - Mismatch: no ack, Standby until Start
// - Ignore bus until reset releases, Standby
// - Below threshold, respond to nothing
// - Data output open drain only
// - Clock input only, times shift both ways
// - Standby after Stop unless write busy
// - Target only, never drives clock
// - Controller initiates and clocks every transfer
// - No select ack while write busy
`timescale 1ns/1ps
`default_nettype none
module smbtf_device
	import smbtf_pkg::*;
#(
	parameter int PROG_CNT = smbtf_pkg::PROG_CYCLES,
	parameter logic [6:0] TARGET_ID = smbtf_pkg::TARGET_ID_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	smbtf_if.device bus,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	output logic busy,
	output logic standby,
	output logic selected,
	output logic read_mode
);
	import smbtf_pkg::*;
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic scl_q_r;
	logic sda_q_r;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	smbtf_state_t st_r;
	logic [3:0] bcnt_r;
	logic [7:0] sh_r;
	logic dir_r;
	logic wr_pend_r;
	logic busy_r;
	logic [31:0] pcnt_r;
	logic sda_oe_r;
	logic rx_valid_r;
	logic [7:0] rx_data_r;
	logic fifo_ready;
	logic [7:0] txs_r;
	logic ackd_r;
	// Sync; only stages 1 and 2 are compared
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[1:0], bus.scl};
			sda_s_r <= {sda_s_r[1:0], bus.sda};
			if (scl_s_r[1] == scl_s_r[2]) begin
				scl_q_r <= scl_s_r[2];
			end
			if (sda_s_r[1] == sda_s_r[2]) begin
				sda_q_r <= sda_s_r[2];
			end
		end
	end
	logic scl_n;
	logic sda_n;
	assign scl_n = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_q_r;
	assign sda_n = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_q_r;
	assign scl_rise = scl_n & ~scl_q_r;
	assign scl_fall = ~scl_n & scl_q_r;
	assign start_det = scl_q_r & scl_n & sda_q_r & ~sda_n & ~busy_r;
	assign stop_det = scl_q_r & scl_n & ~sda_q_r & sda_n & ~busy_r;
	// Main protocol engine
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= SMBTF_STBY;
			bcnt_r <= '0;
			sh_r <= SEL_RESET;
			dir_r <= 1'b0;
			wr_pend_r <= 1'b0;
			sda_oe_r <= 1'b0;
			txs_r <= 8'h00;
			ackd_r <= 1'b0;
		end else if (busy_r) begin
			st_r <= SMBTF_STBY;
			sda_oe_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else if (start_det) begin
			st_r <= SMBTF_SEL;
			bcnt_r <= '0;
			sda_oe_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else if (stop_det) begin
			st_r <= SMBTF_STBY;
			sda_oe_r <= 1'b0;
			wr_pend_r <= 1'b0;
		end else begin
			case (st_r)
			SMBTF_SEL, SMBTF_DATA: begin
				if (scl_rise) begin
					sh_r <= {sh_r[6:0], sda_q_r};
					bcnt_r <= bcnt_r + 4'h1;
				end
				if (scl_fall && st_r == SMBTF_DATA && dir_r) begin
					sda_oe_r <= ~txs_r[7];
					txs_r <= {txs_r[6:0], 1'b1};
				end
				if (scl_fall && bcnt_r == BITS_PER_BYTE) begin
					if (st_r == SMBTF_SEL) begin
						dir_r <= sh_r[SEL_POS_DIR];
						if (sh_r[7:1] == TARGET_ID) begin
							sda_oe_r <= 1'b1;
							st_r <= SMBTF_ACK;
						end else begin
							sda_oe_r <= 1'b0;
							st_r <= SMBTF_STBY;
						end
					end else begin
						sda_oe_r <= ~dir_r;
						st_r <= SMBTF_DACK;
					end
				end
			end
			SMBTF_ACK, SMBTF_DACK: begin
				if (scl_rise) begin
					ackd_r <= ~sda_q_r;
					bcnt_r <= ACK_SLOT;
				end
				if (scl_fall && bcnt_r == ACK_SLOT) begin
					bcnt_r <= '0;
					if (st_r == SMBTF_DACK && !dir_r) begin
						wr_pend_r <= 1'b1;
					end
					if (st_r == SMBTF_DACK && dir_r && !ackd_r) begin
						st_r <= SMBTF_STBY;
						sda_oe_r <= 1'b0;
					end else begin
						st_r <= SMBTF_DATA;
						sda_oe_r <= dir_r ? ~tx_data[7] : 1'b0;
						txs_r <= {tx_data[6:0], 1'b1};
					end
				end
			end
			default: begin
				sda_oe_r <= 1'b0;
			end
			endcase
		end
	end
	// Write cycle timer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			pcnt_r <= '0;
		end else if (busy_r) begin
			if (pcnt_r == 32'(PROG_CNT - 1)) begin
				busy_r <= 1'b0;
			end
			pcnt_r <= pcnt_r + 32'h1;
		end else if (stop_det && wr_pend_r) begin
			busy_r <= 1'b1;
			pcnt_r <= '0;
		end
	end
	// Received write bytes into the FIFO
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_valid_r <= 1'b0;
			rx_data_r <= 8'h00;
		end else begin
			rx_valid_r <= !busy_r && !start_det && !stop_det
				&& st_r == SMBTF_DATA && !dir_r && scl_fall
				&& bcnt_r == BITS_PER_BYTE && fifo_ready;
			rx_data_r <= sh_r;
		end
	end
	logic fifo_ov;
	logic [7:0] fifo_od;
	smbtf_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
		.clk(ref_clk),
		.rst(rst),
		.in_valid(rx_valid_r),
		.in_ready(fifo_ready),
		.in_data(rx_data_r),
		.out_valid(fifo_ov),
		.out_ready(~rx_valid),
		.out_data(fifo_od)
	);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			busy <= 1'b0;
			standby <= 1'b1;
			selected <= 1'b0;
			read_mode <= 1'b0;
		end else begin
			if (rx_valid && rx_ready) begin
				rx_valid <= 1'b0;
			end else if (!rx_valid && fifo_ov) begin
				rx_valid <= 1'b1;
				rx_data <= fifo_od;
			end
			busy <= busy_r;
			standby <= (st_r == SMBTF_STBY) && !busy_r;
			selected <= (st_r == SMBTF_ACK) || (st_r == SMBTF_DATA)
				|| (st_r == SMBTF_DACK);
			read_mode <= dir_r;
		end
	end
	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe = sda_oe_r;
endmodule
`default_nettype wire

// File: rtl/smbtf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module smbtf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rp_r[AW-1:0]];
	always_ff @(posedge clk) begin
		if (in_valid && !full) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full) begin
				wp_r <= wp_r + 1'b1;
			end
			if (out_ready && !empty) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/smbtf_host.sv
`timescale 1ns/1ps
`default_nettype none
module smbtf_host
	import smbtf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	smbtf_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_stop,
	output logic ack_valid,
	output logic ack_seen
);
	import smbtf_pkg::*;
	smbtf_host_state_t st_r;
	logic [3:0] div_r;
	logic [3:0] bit_r;
	logic [8:0] sh_r;
	logic stop_r;
	logic scl_r;
	logic sda_r;
	logic [2:0] sda_s_r;
	logic tick;
	assign tick = (div_r == 4'(CLK_DIV - 1));
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
		end else begin
			div_r <= tick ? 4'h0 : div_r + 4'h1;
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sda_s_r <= 3'h7;
		end else begin
			sda_s_r <= {sda_s_r[1:0], bus.sda};
		end
	end
	// Controller: Start, byte MSB first, ack slot, optional Stop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= SMBTFH_IDLE;
			bit_r <= '0;
			sh_r <= '1;
			stop_r <= 1'b0;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			ack_valid <= 1'b0;
			ack_seen <= 1'b0;
			cmd_ready <= 1'b0;
		end else begin
			ack_valid <= 1'b0;
			cmd_ready <= 1'b0;
			if (tick) begin
				case (st_r)
				SMBTFH_IDLE: begin
					if (cmd_valid) begin
						sda_r <= 1'b0;
						sh_r <= {cmd_byte, 1'b1};
						stop_r <= cmd_stop;
						bit_r <= '0;
						cmd_ready <= 1'b1;
						st_r <= SMBTFH_START;
					end
				end
				SMBTFH_START: begin
					scl_r <= 1'b0;
					st_r <= SMBTFH_LOW;
				end
				SMBTFH_LOW: begin
					sda_r <= sh_r[8];
					scl_r <= 1'b0;
					st_r <= SMBTFH_HIGH;
				end
				SMBTFH_HIGH: begin
					scl_r <= 1'b1;
					if (scl_r) begin
						sh_r <= {sh_r[7:0], 1'b1};
						if (bit_r == BITS_PER_BYTE) begin
							ack_valid <= 1'b1;
							ack_seen <= ~sda_s_r[2];
							st_r <= SMBTFH_STOP1;
						end else begin
							bit_r <= bit_r + 4'h1;
							st_r <= SMBTFH_LOW;
						end
					end
				end
				SMBTFH_STOP1: begin
					scl_r <= 1'b0;
					sda_r <= 1'b0;
					if (stop_r) begin
						st_r <= SMBTFH_STOP2;
					end else if (cmd_valid) begin
						sh_r <= {cmd_byte, 1'b1};
						stop_r <= cmd_stop;
						bit_r <= '0;
						cmd_ready <= 1'b1;
						st_r <= SMBTFH_LOW;
					end
				end
				SMBTFH_STOP2: begin
					if (!scl_r) begin
						scl_r <= 1'b1;
					end else begin
						sda_r <= 1'b1;
						st_r <= SMBTFH_IDLE;
					end
				end
				default: st_r <= SMBTFH_IDLE;
				endcase
			end
		end
	end
	assign bus.scl_o = scl_r;
	assign bus.sda_h_o = 1'b0;
	assign bus.sda_h_oe = ~sda_r;
endmodule
`default_nettype wire

// File: rtl/smbtf_if.sv
`timescale 1ns/1ps
`default_nettype none
interface smbtf_if;
	logic scl_o;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	wire logic sda;
	wire logic scl;
	assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
	assign scl = scl_o;
	modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
	modport host (input scl, input sda, output scl_o, output sda_h_o,
		output sda_h_oe);
endinterface
`default_nettype wire

// File: rtl/smbtf_pkg.sv
package smbtf_pkg;
	localparam int BIT_CNT_W = 4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;
	localparam int SEL_POS_DIR = 0;
	localparam logic [7:0] SEL_RESET = 8'h00;
	// Type identifier plus chip-enable field; arbitrary value
	localparam logic [6:0] TARGET_ID_DEFAULT = 7'h55;
	localparam int REF_CLK_MHZ = 40;
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYCLES = PROG_TIME_US * REF_CLK_MHZ;
	localparam int CLK_DIV = 4;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 8;
	typedef enum logic [2:0] {
		SMBTF_IDLE = 3'b000,
		SMBTF_SEL = 3'b001,
		SMBTF_ACK = 3'b011,
		SMBTF_DATA = 3'b010,
		SMBTF_DACK = 3'b110,
		SMBTF_STBY = 3'b111
	} smbtf_state_t;
	typedef enum logic [2:0] {
		SMBTFH_IDLE = 3'b000,
		SMBTFH_START = 3'b001,
		SMBTFH_LOW = 3'b011,
		SMBTFH_HIGH = 3'b010,
		SMBTFH_STOP1 = 3'b110,
		SMBTFH_STOP2 = 3'b111
	} smbtf_host_state_t;
endpackage

// File: tb/smbtf_bench.sv
`timescale 1ns/1ps
`default_nettype none
module smbtf_bench;
	import smbtf_pkg::*;
	localparam logic [6:0] ID = 7'h2b;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic rx_ready = 1'b0;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_byte = 8'h00;
	logic cmd_stop = 1'b0;
	logic [7:0] rx_data;
	logic rx_valid, busy, standby, selected, read_mode;
	logic cmd_ready, ack_valid, ack_seen, a;
	int fail_count = 0;
	int compares = 0;
	smbtf_if bus_if();
	smbtf_device #(.PROG_CNT(300), .TARGET_ID(ID)) i_smbtf_device (
		.ref_clk(ref_clk), .rst(rst), .bus(bus_if), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(8'hff),
		.busy(busy), .standby(standby), .selected(selected),
		.read_mode(read_mode));
	smbtf_host i_smbtf_host (.ref_clk(ref_clk), .rst(rst), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_byte(cmd_byte),
		.cmd_stop(cmd_stop), .ack_valid(ack_valid), .ack_seen(ack_seen));
	smbtf_chk i_smbtf_chk (.ref_clk(ref_clk), .rst(rst), .scl(bus_if.scl),
		.sda(bus_if.sda), .sda_d_o(bus_if.sda_d_o),
		.sda_d_oe(bus_if.sda_d_oe));
	always #12.5 ref_clk = ~ref_clk;
	task automatic complete_run();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bounded wait: 0 command taken, 1 ack slot done, 2 write finished
	task automatic await(input int w);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!((w == 0 && cmd_ready === 1'b1) ||
			(w == 1 && ack_valid === 1'b1) || (w == 2 && busy === 1'b0))
			&& n < 1000);
		if (n >= 1000) begin
			fail_count++;
			complete_run();
		end
	endtask
	task automatic send(input logic [7:0] b, input logic s);
		cmd_valid <= 1'b1;
		cmd_byte <= b;
		cmd_stop <= s;
		await(0);
		cmd_valid <= 1'b0;
		await(1);
		a = ack_seen;
		if (s) begin
			repeat (24) @(posedge ref_clk);
		end
	endtask
	task automatic pop();
		rx_ready <= 1'b1;
		@(posedge ref_clk);
		rx_ready <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		chk("standby", 8'h01, 8'(standby));
		chk("busy", 8'h00, 8'(busy));
		chk("sda", 8'h01, 8'(bus_if.sda));
		chk("scl", 8'h01, 8'(bus_if.scl));
	endtask
	task automatic t_write();
		send({ID, 1'b0}, 1'b0);
		chk("sel_ack", 8'h01, 8'(a));
		chk("read_mode", 8'h00, 8'(read_mode));
		chk("standby", 8'h00, 8'(standby));
		send(8'h3c, 1'b0);
		send(8'hc5, 1'b1);
		chk("busy", 8'h01, 8'(busy));
		chk("rx0", 8'h3c, rx_data);
		pop();
		chk("rx1", 8'hc5, rx_data);
		pop();
		chk("rx_valid", 8'h00, 8'(rx_valid));
		send({ID, 1'b0}, 1'b1);
		chk("busy_ack", 8'h00, 8'(a));
		await(2);
		chk("standby", 8'h01, 8'(standby));
		send({ID, 1'b0}, 1'b1);
		chk("poll_ack", 8'h01, 8'(a));
		chk("busy", 8'h00, 8'(busy));
	endtask
	task automatic t_other();
		send({~ID, 1'b0}, 1'b1);
		chk("bad_ack", 8'h00, 8'(a));
		chk("selected", 8'h00, 8'(selected));
		send({ID, 1'b1}, 1'b0);
		chk("rd_ack", 8'h01, 8'(a));
		chk("read_mode", 8'h01, 8'(read_mode));
		send(8'hff, 1'b1);
		chk("standby", 8'h01, 8'(standby));
		chk("busy", 8'h00, 8'(busy));
	endtask
	// Write burst held unread, then drained through the design's output
	task automatic t_fifo();
		send({ID, 1'b0}, 1'b0);
		for (int i = 0; i < FIFO_D; i++) begin
			send(8'h10 + 8'(i), i == FIFO_D - 1);
		end
		chk("fifo_fill", 8'h01, 8'(rx_valid));
		for (int i = 0; i < FIFO_D; i++) begin
			chk("fifo_data", 8'h10 + 8'(i), rx_data);
			pop();
		end
		chk("fifo_drain", 8'h00, 8'(rx_valid));
		await(2);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		t_reset();
		t_write();
		t_other();
		t_fifo();
		complete_run();
	end
endmodule
`default_nettype wire

// File: tb/smbtf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module smbtf_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_o,
	input wire logic sda_d_oe
);
	logic scl_q_r, sda_q_r, start_w, stop_w;
	logic [3:0] fall_cnt_r;
	assign start_w = scl && scl_q_r && sda_q_r && !sda;
	assign stop_w = scl && scl_q_r && !sda_q_r && sda;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl;
			sda_q_r <= sda;
		end
	end
	// Clock falls since Start, wrapping per byte plus ack
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fall_cnt_r <= 4'h0;
		end else if (start_w) begin
			fall_cnt_r <= 4'h0;
		end else if (scl_q_r && !scl) begin
			fall_cnt_r <= (fall_cnt_r == 4'h9) ? 4'h1 : fall_cnt_r + 4'h1;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_OPEN_DRAIN: assert property (sda_d_oe |-> sda_d_o == 1'b0)
		else $error("device drove data high");
	AST_QUIET_AFTER_RESET: assert property ($fell(rst) |-> !sda_d_oe [*8])
		else $error("device drove data right after reset");
	AST_ACK_SLOT: assert property ($rose(sda_d_oe) |-> fall_cnt_r == 4'h9)
		else $error("device pulled data outside the ninth slot");
	AST_ACK_LENGTH: assert property ($rose(sda_d_oe) |->
		sda_d_oe [*8] ##[1:8] !sda_d_oe)
		else $error("acknowledge not held for one clock period");
	AST_STABLE_HIGH: assert property ($rose(scl) |->
		##1 $stable(sda_d_oe) [*3])
		else $error("device changed data while clock high");
	AST_STOP_RELEASE: assert property (stop_w |-> !sda_d_oe [*8])
		else $error("device still drove data after Stop");
	AST_START_QUIET: assert property (start_w |-> !sda_d_oe [*8])
		else $error("device drove data right after Start");
	AST_SCL_HIGH_HOLD: assert property ($rose(scl) |-> scl [*4])
		else $error("clock high phase too short");
	cover property ($rose(sda_d_oe));
	cover property (stop_w);
	cover property (start_w);
endmodule
`default_nettype wire
